/* File: rtl/cab_defs.svh */
`ifndef CAB_DEFS_SVH
`define CAB_DEFS_SVH
// What this block does
// (RQ1) Set-bits ORs register with mask, updates Z N V S, one cycle.
// (RQ2) Clear-bits ANDs register with inverted mask, sets Z N V S, one cycle.
// (RQ3) Test ANDs register with itself, value kept, Z N V S, one cycle.
// (RQ4) Multiplies (UU, SS, SU) put 16-bit product in R1:R0, Z C, two cycles.
// (RQ5) Fractional multiplies shift product left one, same flags and timing.
// (RQ6) DES step encrypts with H clear, decrypts with H set, 1 or 2 cycles.
// (RQ7) Pointer jump: PC low from Z, PC bits 21..16 cleared, two cycles.
// (RQ8) Extended pointer jump: PC low from Z, high from extension, two cycles.
// (RQ9) Pointer call pushes return, PC from Z, upper zero, 2 or 3 cycles.
// (RQ10) Extended pointer call pushes return, high bits from extension, 3 cycles.
// (RQ11) Compare-skip: equal registers skip next 1 or 2 words, flags kept.
// (RQ12) Register bit skips test bit b, skip on clear or set, flags untouched.
// (RQ13) I/O bit skips test bit b of I/O value, two to four cycles.
// (RQ14) Branch on flag set adds k plus one to PC; one or two cycles.
// (RQ15) False skip or branch continues sequentially with the least cycle count.
`define CAB_IDX_CTRL   4'h0
`define CAB_IDX_OPER   4'h1
`define CAB_IDX_FLAGS  4'h2
`define CAB_IDX_ZPTR   4'h3
`define CAB_IDX_PC     4'h4
`define CAB_IDX_RESULT 4'h5
`define CAB_IDX_STATE  4'h6
`define CAB_IDX_RET    4'h7
`define CAB_IDX_DESLO  4'h8
`define CAB_IDX_DESHI  4'h9
`define CAB_IDX_IO     4'ha
`define CAB_CTRL_GO    31
`define CAB_FLAG_C     3'h0
`define CAB_FLAG_Z     3'h1
`define CAB_FLAG_N     3'h2
`define CAB_FLAG_V     3'h3
`define CAB_FLAG_S     3'h4
`define CAB_FLAG_H     3'h5
`define CAB_OPER_TWO   27
`define CAB_OPER_WIDE  28
`define CAB_CYC_1      3'h1
`define CAB_CYC_2      3'h2
`define CAB_CYC_3      3'h3
`define CAB_CYC_4      3'h4
`define CAB_PC_ONE     22'h000001
`define CAB_PC_TWO     22'h000002
`define CAB_PC_THREE   22'h000003
`define CAB_PC_RST     22'h000000
`endif

/* File: rtl/cab_pkg.sv */
package cab_pkg;
    typedef enum logic [4:0] {
        set_bits_op, clear_bits_op, test_zero_minus_op,
        multiply_unsigned_op, multiply_signed_op, multiply_mixed_sign_op,
        fractional_multiply_op, fractional_signed_op,
        fractional_mixed_multiply_op, des_step_op,
        pointer_jump_op, extended_pointer_jump_op,
        pointer_call_op, extended_pointer_call_op,
        compare_skip_equal_op, skip_reg_bit_clear_op, skip_reg_bit_set_op,
        skip_io_bit_clear_op, skip_io_bit_set_op, branch_flag_set_op
    } cab_op_e;
    typedef enum logic {
        cab_idle = 1'b0,
        cab_run  = 1'b1
    } cab_state_e;
endpackage : cab_pkg

/* File: rtl/cab_exec.sv */
// Decided for this implementation: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
`include "cab_defs.svh"
module cab_exec (
    input  wire logic        clock_in,
    input  wire logic        rst_in,
    input  wire logic [5:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    input  wire logic [3:0]  avs_byteenable_in,
    output logic      [31:0] avs_readdata_out,
    output logic             avs_waitrequest_out,
    output logic             exec_busy_out
);
    // Byte-lane merge of a write into a stored word
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    // Logic-result flags: Z N V S, V forced low
    function automatic logic [7:0] logic_flags(input logic [7:0] f,
                                               input logic [7:0] res);
        logic [7:0] r;
        r = f;
        r[`CAB_FLAG_Z] = (res == 8'h00);
        r[`CAB_FLAG_N] = res[7];
        r[`CAB_FLAG_V] = 1'b0;
        r[`CAB_FLAG_S] = res[7];
        return r;
    endfunction : logic_flags

    // Feistel round function for the DES step
    function automatic logic [31:0] round_f(input logic [31:0] h,
                                            input logic [7:0]  k);
        return {h[30:0], h[31]} ^ {4{k}};
    endfunction : round_f

    logic              wait_reg;
    logic [31:0]       rdata_reg;
    cab_pkg::cab_state_e state_reg;
    logic [2:0]        cnt_reg;
    logic [4:0]        op_reg;
    logic [28:0]       oper_reg;
    logic [7:0]        flags_reg;
    logic [21:0]       zptr_reg;
    logic [21:0]       pc_reg;
    logic [7:0]        res_reg;
    logic [15:0]       prod_reg;
    logic [21:0]       ret_reg;
    logic [63:0]       des_reg;
    logic [7:0]        io_reg;
    logic              skip_reg;
    logic              last_des_reg;
    logic [2:0]        taken_reg;

    logic              req;
    logic              wr_ok;
    logic [3:0]        idx;
    logic              go;
    logic [7:0]        rd;
    logic [7:0]        rr;
    logic [7:0]        kk;
    logic [2:0]        bsel;
    logic [8:0]        a9;
    logic [8:0]        b9;
    logic [17:0]       p18;
    logic [15:0]       prod;
    logic [7:0]        res_next;
    logic [7:0]        flags_next;
    logic [15:0]       prod_next;
    logic [21:0]       pc_next;
    logic [63:0]       des_next;
    logic [2:0]        cyc_next;
    logic              skip_next;
    logic              wr_res;
    logic              wr_prod;
    logic              wr_ret;
    logic [21:0]       seq_pc;
    logic [21:0]       skip_pc;
    logic [21:0]       br_off;

    assign req   = avs_read_in | avs_write_in;
    assign wr_ok = avs_write_in & ~wait_reg;
    assign idx   = avs_address_in[5:2];
    assign go    = wr_ok & (idx == `CAB_IDX_CTRL)
                 & avs_writedata_in[`CAB_CTRL_GO] & avs_byteenable_in[3]
                 & (state_reg == cab_pkg::cab_idle);
    assign rd    = oper_reg[7:0];
    assign rr    = oper_reg[15:8];
    assign kk    = oper_reg[23:16];
    assign bsel  = oper_reg[26:24];
    assign seq_pc  = pc_reg + `CAB_PC_ONE;
    assign skip_pc = pc_reg + (oper_reg[`CAB_OPER_TWO] ? `CAB_PC_THREE
                                                       : `CAB_PC_TWO);
    assign br_off  = {{15{kk[6]}}, kk[6:0]};

    // Sign extension per multiply flavour
    always_comb begin
        unique case (cab_pkg::cab_op_e'(op_reg))
            cab_pkg::multiply_signed_op, cab_pkg::fractional_signed_op: begin
                a9 = {rd[7], rd};
                b9 = {rr[7], rr};
            end
            cab_pkg::multiply_mixed_sign_op,
            cab_pkg::fractional_mixed_multiply_op: begin
                a9 = {rd[7], rd};
                b9 = {1'b0, rr};
            end
            default: begin
                a9 = {1'b0, rd};
                b9 = {1'b0, rr};
            end
        endcase
    end
    assign p18  = {{9{a9[8]}}, a9} * {{9{b9[8]}}, b9};
    assign prod = p18[15:0];

    // Result, flags, PC and cycle count of the held instruction
    always_comb begin
        res_next   = res_reg;
        flags_next = flags_reg;
        prod_next  = prod_reg;
        pc_next    = seq_pc;
        des_next   = des_reg;
        cyc_next   = `CAB_CYC_1;
        skip_next  = 1'b0;
        wr_res     = 1'b0;
        wr_prod    = 1'b0;
        wr_ret     = 1'b0;
        unique case (cab_pkg::cab_op_e'(op_reg))
            cab_pkg::set_bits_op: begin
                res_next   = rd | kk; // [RQ1]
                flags_next = logic_flags(flags_reg, rd | kk); // [RQ1]
                wr_res     = 1'b1;
            end
            cab_pkg::clear_bits_op: begin
                res_next   = rd & ~kk; // [RQ2]
                flags_next = logic_flags(flags_reg, rd & ~kk); // [RQ2]
                wr_res     = 1'b1;
            end
            cab_pkg::test_zero_minus_op: begin
                res_next   = rd & rd; // [RQ3]
                flags_next = logic_flags(flags_reg, rd); // [RQ3]
                wr_res     = 1'b1;
            end
            cab_pkg::multiply_unsigned_op, cab_pkg::multiply_signed_op,
            cab_pkg::multiply_mixed_sign_op: begin
                prod_next = prod; // [RQ4]
                flags_next[`CAB_FLAG_C] = prod[15];
                flags_next[`CAB_FLAG_Z] = (prod == 16'h0000);
                cyc_next  = `CAB_CYC_2; // [RQ4]
                wr_prod   = 1'b1;
            end
            cab_pkg::fractional_multiply_op, cab_pkg::fractional_signed_op,
            cab_pkg::fractional_mixed_multiply_op: begin
                prod_next = {prod[14:0], 1'b0}; // [RQ5]
                flags_next[`CAB_FLAG_C] = prod[15]; // [RQ5]
                flags_next[`CAB_FLAG_Z] = (prod[14:0] == 15'h0000);
                cyc_next  = `CAB_CYC_2; // [RQ5]
                wr_prod   = 1'b1;
            end
            cab_pkg::des_step_op: begin
                if (flags_reg[`CAB_FLAG_H]) begin
                    des_next = {des_reg[31:0] ^ round_f(des_reg[63:32], kk),
                                des_reg[63:32]}; // [RQ6]
                end else begin
                    des_next = {des_reg[31:0],
                                des_reg[63:32] ^ round_f(des_reg[31:0], kk)};
                end
                cyc_next = last_des_reg ? `CAB_CYC_1 : `CAB_CYC_2; // [RQ6]
            end
            cab_pkg::pointer_jump_op: begin
                pc_next  = {6'h00, zptr_reg[15:0]}; // [RQ7]
                cyc_next = `CAB_CYC_2; // [RQ7]
            end
            cab_pkg::extended_pointer_jump_op: begin
                pc_next  = zptr_reg; // [RQ8]
                cyc_next = `CAB_CYC_2; // [RQ8]
            end
            cab_pkg::pointer_call_op: begin
                pc_next  = {6'h00, zptr_reg[15:0]}; // [RQ9]
                wr_ret   = 1'b1; // [RQ9]
                cyc_next = oper_reg[`CAB_OPER_WIDE] ? `CAB_CYC_3
                                                    : `CAB_CYC_2; // [RQ9]
            end
            cab_pkg::extended_pointer_call_op: begin
                pc_next  = zptr_reg; // [RQ10]
                wr_ret   = 1'b1; // [RQ10]
                cyc_next = `CAB_CYC_3; // [RQ10]
            end
            cab_pkg::compare_skip_equal_op: begin
                skip_next = (rd == rr); // [RQ11]
            end
            cab_pkg::skip_reg_bit_clear_op: begin
                skip_next = ~rd[bsel]; // [RQ12]
            end
            cab_pkg::skip_reg_bit_set_op: begin
                skip_next = rd[bsel]; // [RQ12]
            end
            cab_pkg::skip_io_bit_clear_op: begin
                skip_next = ~io_reg[bsel]; // [RQ13]
                cyc_next  = `CAB_CYC_2; // [RQ13]
            end
            cab_pkg::skip_io_bit_set_op: begin
                skip_next = io_reg[bsel]; // [RQ13]
                cyc_next  = `CAB_CYC_2;
            end
            cab_pkg::branch_flag_set_op: begin
                if (flags_reg[bsel]) begin
                    pc_next  = seq_pc + br_off; // [RQ14]
                    cyc_next = `CAB_CYC_2; // [RQ14]
                end
            end
            default: begin
                cyc_next = `CAB_CYC_1;
            end
        endcase
        if (skip_next) begin
            pc_next  = skip_pc; // [RQ11] [RQ12] [RQ13]
            cyc_next = cyc_next + (oper_reg[`CAB_OPER_TWO] ? `CAB_CYC_2
                                                          : `CAB_CYC_1);
        end
    end

    // Bus handshake: one wait cycle per access
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            wait_reg <= 1'b1;
        end else begin
            wait_reg <= ~(req & wait_reg);
        end
    end

    // Read data captured in the wait cycle
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_reg <= 32'h00000000;
        end else if (avs_read_in & wait_reg) begin
            unique case (idx)
                `CAB_IDX_CTRL:   rdata_reg <= {27'h0000000, op_reg};
                `CAB_IDX_OPER:   rdata_reg <= {3'h0, oper_reg};
                `CAB_IDX_FLAGS:  rdata_reg <= {24'h000000, flags_reg};
                `CAB_IDX_ZPTR:   rdata_reg <= {10'h000, zptr_reg};
                `CAB_IDX_PC:     rdata_reg <= {10'h000, pc_reg};
                `CAB_IDX_RESULT: rdata_reg <= {8'h00, res_reg, prod_reg};
                `CAB_IDX_STATE:  rdata_reg <= {27'h0000000, taken_reg,
                                               skip_reg, state_reg};
                `CAB_IDX_RET:    rdata_reg <= {10'h000, ret_reg};
                `CAB_IDX_DESLO:  rdata_reg <= des_reg[31:0];
                `CAB_IDX_DESHI:  rdata_reg <= des_reg[63:32];
                `CAB_IDX_IO:     rdata_reg <= {24'h000000, io_reg};
                default:         rdata_reg <= 32'h00000000;
            endcase
        end
    end

    // Sequencer: start, count up, finish
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            state_reg <= cab_pkg::cab_idle;
            cnt_reg   <= `CAB_CYC_1;
        end else if (go) begin
            state_reg <= cab_pkg::cab_run;
            cnt_reg   <= `CAB_CYC_1;
        end else if (state_reg == cab_pkg::cab_run) begin
            cnt_reg <= cnt_reg + `CAB_CYC_1;
            if (cnt_reg == cyc_next) begin
                state_reg <= cab_pkg::cab_idle;
            end
        end
    end

    logic done;
    assign done = (state_reg == cab_pkg::cab_run) & (cnt_reg == cyc_next);

    // Software-written operands, ignored while running
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            op_reg   <= 5'h00;
            oper_reg <= 29'h00000000;
            zptr_reg <= 22'h000000;
            io_reg   <= 8'h00;
        end else if (wr_ok && state_reg == cab_pkg::cab_idle) begin
            unique case (idx)
                `CAB_IDX_CTRL: op_reg <= 5'(merge({27'h0, op_reg},
                    avs_writedata_in, avs_byteenable_in));
                `CAB_IDX_OPER: oper_reg <= 29'(merge({3'h0, oper_reg},
                    avs_writedata_in, avs_byteenable_in));
                `CAB_IDX_ZPTR: zptr_reg <= 22'(merge({10'h0, zptr_reg},
                    avs_writedata_in, avs_byteenable_in));
                `CAB_IDX_IO: io_reg <= 8'(merge({24'h0, io_reg},
                    avs_writedata_in, avs_byteenable_in));
                default: io_reg <= io_reg;
            endcase
        end
    end

    // Architectural state: software write when idle, update at finish
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            flags_reg <= 8'h00;
            pc_reg    <= `CAB_PC_RST;
            des_reg   <= 64'h0000000000000000;
        end else if (done) begin
            flags_reg <= flags_next;
            pc_reg    <= pc_next; // [RQ15]
            des_reg   <= des_next;
        end else if (wr_ok && state_reg == cab_pkg::cab_idle) begin
            unique case (idx)
                `CAB_IDX_FLAGS: flags_reg <= 8'(merge({24'h0, flags_reg},
                    avs_writedata_in, avs_byteenable_in));
                `CAB_IDX_PC: pc_reg <= 22'(merge({10'h0, pc_reg},
                    avs_writedata_in, avs_byteenable_in));
                `CAB_IDX_DESLO: des_reg[31:0] <= merge(des_reg[31:0],
                    avs_writedata_in, avs_byteenable_in);
                `CAB_IDX_DESHI: des_reg[63:32] <= merge(des_reg[63:32],
                    avs_writedata_in, avs_byteenable_in);
                default: pc_reg <= pc_reg;
            endcase
        end
    end

    // Results of the finished instruction
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            res_reg      <= 8'h00;
            prod_reg     <= 16'h0000;
            ret_reg      <= `CAB_PC_RST;
            skip_reg     <= 1'b0;
            last_des_reg <= 1'b0;
            taken_reg    <= 3'h0;
        end else if (done) begin
            if (wr_res) res_reg <= res_next;
            if (wr_prod) prod_reg <= prod_next;
            if (wr_ret) ret_reg <= seq_pc;
            skip_reg     <= skip_next;
            last_des_reg <= (op_reg == 5'(cab_pkg::des_step_op));
            taken_reg    <= cyc_next;
        end
    end

    assign avs_readdata_out    = rdata_reg;
    assign avs_waitrequest_out = wait_reg;
    assign exec_busy_out       = state_reg;
endmodule : cab_exec

/* File: verif/cab_exec_chk.sv */
`timescale 1ns/1ps
module cab_exec_chk (
    input wire logic        clock_in,
    input wire logic        rst_in,
    input wire logic [5:0]  avs_address_in,
    input wire logic        avs_read_in,
    input wire logic        avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0]  avs_byteenable_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic        avs_waitrequest_out,
    input wire logic        exec_busy_out
);
    logic       start;
    logic [4:0] op;
    // Accepted go write while idle
    assign start = avs_write_in && !avs_waitrequest_out &&
                   avs_address_in[5:2] == 4'h0 && avs_writedata_in[31] &&
                   avs_byteenable_in[3] && !exec_busy_out;
    assign op = avs_writedata_in[4:0];
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);
    AST_LOGIC_ONE: assert property (
        start && op <= 5'h02 |=> exec_busy_out ##1 !exec_busy_out)
        else $error("logic op not one cycle");
    AST_MUL_TWO: assert property (
        start && op inside {[5'h03:5'h05]} |=>
        exec_busy_out [*2] ##1 !exec_busy_out)
        else $error("multiply not two cycles");
    AST_FRACTIONAL_MULTIPLY_OP_TWO: assert property (
        start && op inside {[5'h06:5'h08]} |=>
        exec_busy_out [*2] ##1 !exec_busy_out)
        else $error("fractional multiply not two cycles");
    AST_DES_CYC: assert property (
        start && op == 5'h09 |=> exec_busy_out ##[1:2] !exec_busy_out)
        else $error("des step not one or two cycles");
    AST_JMP_TWO: assert property (
        start && op inside {5'h0a, 5'h0b} |=>
        exec_busy_out [*2] ##1 !exec_busy_out)
        else $error("pointer jump not two cycles");
    AST_CALL_CYC: assert property (
        start && op == 5'h0c |=> exec_busy_out [*2] ##[1:2] !exec_busy_out)
        else $error("pointer call not two or three cycles");
    AST_ECALL_THREE: assert property (
        start && op == 5'h0d |=> exec_busy_out [*3] ##1 !exec_busy_out)
        else $error("extended call not three cycles");
    AST_SKIP_REG: assert property (
        start && op inside {[5'h0e:5'h10]} |=>
        exec_busy_out ##[1:3] !exec_busy_out)
        else $error("register skip not one to three cycles");
    AST_SKIP_IO: assert property (
        start && op inside {5'h11, 5'h12} |=>
        exec_busy_out [*2] ##[1:3] !exec_busy_out)
        else $error("io skip not two to four cycles");
    AST_BRANCH: assert property (
        start && op == 5'h13 |=> exec_busy_out ##[1:2] !exec_busy_out)
        else $error("branch not one or two cycles");
    cover property (start && op == 5'h09);
    cover property (start && op == 5'h0d);
    cover property (start && op == 5'h13);
endmodule : cab_exec_chk

/* File: verif/cab_exec_tb.sv */
`timescale 1ns/1ps
module cab_exec_tb;
    logic        clock_in = 1'b0;
    logic        rst_in = 1'b1;
    logic [5:0]  avs_address_in = 6'h00;
    logic        avs_read_in = 1'b0;
    logic        avs_write_in = 1'b0;
    logic [31:0] avs_writedata_in = 32'h0;
    logic [3:0]  avs_byteenable_in = 4'hf;
    logic [31:0] avs_readdata_out;
    logic        avs_waitrequest_out;
    logic        exec_busy_out;
    int          miscompares = 0;
    int          tests_run = 0;
    logic [31:0] d;
    logic [4:0]  top[10] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05,
                              5'h06, 5'h07, 5'h08, 5'h03};
    logic [31:0] topr[10] = '{32'h0081_0040, 32'h0081_0081, 32'h0000_0080,
                              32'h82c0, 32'h82c0, 32'h82c0, 32'h82c0,
                              32'h82c0, 32'h82c0, 32'h8200};
    logic [31:0] tres[10] = '{32'hc1_0000, 32'h0, 32'h80_0000, 32'h6180,
                              32'h1f80, 32'hdf80, 32'hc300, 32'h3f00,
                              32'hbf00, 32'h0};
    logic [7:0]  tfl[10] = '{8'h35, 8'h23, 8'h35, 8'h34, 8'h34, 8'h35,
                             8'h34, 8'h34, 8'h35, 8'h36};
    cab_exec dut_u (
        .clock_in           (clock_in),
        .rst_in             (rst_in),
        .avs_address_in     (avs_address_in),
        .avs_read_in        (avs_read_in),
        .avs_write_in       (avs_write_in),
        .avs_writedata_in   (avs_writedata_in),
        .avs_byteenable_in  (avs_byteenable_in),
        .avs_readdata_out   (avs_readdata_out),
        .avs_waitrequest_out(avs_waitrequest_out),
        .exec_busy_out      (exec_busy_out)
    );
    always #25 clock_in = ~clock_in;
    task automatic conclude();
        $display("compares %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : conclude
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic bus(input logic wr, input logic [3:0] idx,
                       input logic [31:0] wd, output logic [31:0] rd);
        int n;
        n = 0;
        avs_address_in <= {idx, 2'b00};
        avs_write_in <= wr;
        avs_read_in <= !wr;
        avs_writedata_in <= wd;
        do begin
            @(posedge clock_in);
            n++;
        end while (avs_waitrequest_out !== 1'b0 && n < 50);
        if (n >= 50) begin
            miscompares++;
            conclude();
        end
        rd = avs_readdata_out;
        avs_read_in <= 1'b0;
        avs_write_in <= 1'b0;
        @(posedge clock_in);
    endtask : bus
    task automatic exe(input logic [4:0] op, input logic [31:0] oper,
                       input logic [21:0] pc, input logic [2:0] cyc);
        logic [31:0] r;
        int          n;
        n = 0;
        bus(1'b1, 4'h1, oper, r);
        bus(1'b1, 4'h0, {1'b1, 26'h0, op}, r);
        r = 32'h1;
        while (r[0] !== 1'b0 && n < 20) begin
            bus(1'b0, 4'h6, 32'h0, r);
            n++;
        end
        chk("busy", 32'h0, {31'h0, r[0]});
        chk("cycles", {29'h0, cyc}, {29'h0, r[4:2]});
        bus(1'b0, 4'h4, 32'h0, r);
        chk("pc", {10'h0, pc}, r);
    endtask : exe
    initial begin
        repeat (16) @(posedge clock_in);
        rst_in <= 1'b0;
        @(posedge clock_in);
        bus(1'b0, 4'h6, 32'h0, d);
        chk("state_rst", 32'h0, d);
        bus(1'b0, 4'hb, 32'h0, d);
        chk("unmapped", 32'h0, d);
        bus(1'b1, 4'h2, 32'h21, d);
        for (int i = 0; i < 10; i++) begin
            exe(top[i], topr[i], 22'(i + 1), (i < 3) ? 3'h1 : 3'h2);
            bus(1'b0, 4'h5, 32'h0, d);
            d = d & ((i < 3) ? 32'hff_0000 : 32'hffff);
            chk("result", tres[i], d);
            bus(1'b0, 4'h2, 32'h0, d);
            chk("flags", 32'(tfl[i]), 32'(d[7:0]));
        end
        $display("test logic and multiply done");
        bus(1'b1, 4'h8, 32'h12345678, d);
        bus(1'b1, 4'h9, 32'h9abcdef0, d);
        bus(1'b1, 4'h2, 32'h16, d);
        exe(5'h09, 32'h5a_0000, 22'h00000b, 3'h2);
        bus(1'b0, 4'h8, 32'h0, d);
        chk("des_changed", 32'h1, {31'h0, d !== 32'h12345678});
        bus(1'b1, 4'h2, 32'h36, d);
        exe(5'h09, 32'h5a_0000, 22'h00000c, 3'h1);
        bus(1'b0, 4'h8, 32'h0, d);
        chk("des_lo", 32'h12345678, d);
        bus(1'b0, 4'h9, 32'h0, d);
        chk("des_hi", 32'h9abcdef0, d);
        $display("test des done");
        bus(1'b1, 4'h3, 32'h2a_beef, d);
        exe(5'h0a, 32'h0, 22'h00beef, 3'h2);
        exe(5'h0b, 32'h0, 22'h2abeef, 3'h2);
        exe(5'h0c, 32'h0, 22'h00beef, 3'h2);
        bus(1'b0, 4'h7, 32'h0, d);
        chk("ret", 32'h2abef0, d);
        exe(5'h0c, 32'h1000_0000, 22'h00beef, 3'h3);
        exe(5'h0d, 32'h0, 22'h2abeef, 3'h3);
        bus(1'b0, 4'h7, 32'h0, d);
        chk("ret", 32'h00bef0, d);
        $display("test jumps and calls done");
        exe(5'h0e, 32'h0800_5555, 22'h2abef2, 3'h3);
        bus(1'b0, 4'h6, 32'h0, d);
        chk("skip_taken", 32'h1, {31'h0, d[1]});
        exe(5'h0e, 32'h0800_5655, 22'h2abef3, 3'h1);
        bus(1'b0, 4'h6, 32'h0, d);
        chk("skip_none", 32'h0, {31'h0, d[1]});
        exe(5'h10, 32'h0300_0808, 22'h2abef5, 3'h2);
        exe(5'h0f, 32'h0300_0808, 22'h2abef6, 3'h1);
        bus(1'b1, 4'ha, 32'h08, d);
        exe(5'h12, 32'h0b00_0000, 22'h2abef9, 3'h4);
        exe(5'h11, 32'h0b00_0000, 22'h2abefa, 3'h2);
        exe(5'h13, 32'h027e_0000, 22'h2abef9, 3'h2);
        exe(5'h13, 32'h007e_0000, 22'h2abefa, 3'h1);
        bus(1'b0, 4'h2, 32'h0, d);
        chk("flags_kept", 32'h36, {24'h0, d[7:0]});
        $display("test skips and branches done");
        conclude();
    end
endmodule : cab_exec_tb
bind cab_exec cab_exec_chk chk_u (
    .clock_in           (clock_in),
    .rst_in             (rst_in),
    .avs_address_in     (avs_address_in),
    .avs_read_in        (avs_read_in),
    .avs_write_in       (avs_write_in),
    .avs_writedata_in   (avs_writedata_in),
    .avs_byteenable_in  (avs_byteenable_in),
    .avs_readdata_out   (avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out),
    .exec_busy_out      (exec_busy_out)
);
